/* File: avs_frame_master.sv */
// Far-side model: adaptive bus master sending write frames.
// Assumes the bench calls send_frame; link clock idles unless run_link is set or a frame is in flight.
module avs_frame_master (
  input wire logic run_link,
  output logic link_clk,
  output logic frame_valid,
  output logic frame_channel,
  output logic [15:0] frame_value
);
  timeunit 1ns;
  timeprecision 100ps;
  logic busy; // Frame in flight keeps the clock going
  // Link clock, 15 ns, stands still unless running or framing
  initial begin
    link_clk = 1'b0;
    busy = 1'b0;
    frame_valid = 1'b0;
    frame_channel = 1'b0;
    frame_value = 16'h0000;
  end
  always begin
    #7.5;
    if (run_link || busy) link_clk = ~link_clk;
  end
  // One whole frame; released lines show the inverse value
  task send_frame(input logic ch, input logic [15:0] val);
    busy = 1'b1;
    @(negedge link_clk);
    frame_valid = 1'b1;
    frame_channel = ch;
    frame_value = val;
    @(negedge link_clk);
    frame_valid = 1'b0;
    frame_channel = ~ch;
    frame_value = ~val;
    repeat (2) @(negedge link_clk);
    busy = 1'b0;
  endtask : send_frame
endmodule : avs_frame_master

/* File: avs_mode_chk.sv */
// Checker for the mode and configuration logic.
// Assumes it is bound to the top module; page tracked from commands.
module avs_mode_chk (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [1:0] nvm_mode_enable,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  input wire logic rsp_valid,
  input wire logic rsp_ack,
  input wire logic [15:0] rsp_rdata,
  input wire logic smb_alert_n,
  input wire logic bus_io_level_select,
  input wire logic [1:0] channel_adaptive,
  input wire logic [1:0] startup_submode
);
  timeunit 1ns;
  timeprecision 100ps;
  logic page; // Shadow of the page select
  logic [2:0] up_cnt; // Cycles since reset release, saturating
  logic [1:0] nvm_q; // Enable bits seen at power-up
  wire logic wr = cmd_valid && cmd_write;
  // Page shadow
  always_ff @(posedge core_clk) begin
    if (sys_rst) page <= 1'b0;
    else if (wr && cmd_code == 8'h00) page <= cmd_wdata[0];
  end
  // Power-up counter; mode is settled once it saturates
  always_ff @(posedge core_clk) begin
    if (sys_rst) up_cnt <= 3'h0;
    else if (up_cnt != 3'h4) up_cnt <= up_cnt + 3'h1;
  end
  always_ff @(posedge core_clk) begin
    if (!sys_rst && up_cnt == 3'h0) nvm_q <= nvm_mode_enable;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  mode_from_nvm_a: assert property (up_cnt == 3'h4 |->
    channel_adaptive == nvm_q) else $error("mode differs from stored");
  mode_held_a: assert property (up_cnt == 3'h4 && $past(up_cnt) == 3'h4
    |-> $stable(channel_adaptive)) else $error("mode moved");
  trim_nack_a: assert property (cmd_valid && channel_adaptive[page] &&
    cmd_code inside {8'hD4, 8'hD5, 8'hD6} |=> rsp_valid && !rsp_ack)
    else $error("trim not refused");
  protect_alert_a: assert property (wr && cmd_code == 8'hEA &&
    channel_adaptive[page] |=> rsp_ack ##[0:1] !smb_alert_n)
    else $error("no alert on protected write");
  reserved_zero_a: assert property (cmd_valid && !cmd_write &&
    cmd_code == 8'hE9 |=> (rsp_rdata & ~avs_mode_pkg::CFG_WRITABLE_MASK)
    == 16'h0000) else $error("reserved bits set");
  page1_io_a: assert property (cmd_valid && !cmd_write && page &&
    cmd_code == 8'hE9 |=> !rsp_rdata[5]) else $error("page 1 io set");
  io_follow_a: assert property (wr && cmd_code == 8'hE9 && !page
    |-> ##2 bus_io_level_select == $past(cmd_wdata[5], 2))
    else $error("io level wrong");
  startup_needs_a: assert property (
    (startup_submode & ~channel_adaptive) == 2'b00)
    else $error("startup outside adaptive");
  startup_enter_a: assert property (wr && cmd_code == 8'hE9 &&
    cmd_wdata[4] && channel_adaptive[page] |-> ##3 startup_submode[page])
    else $error("startup not entered");
  startup_leave_a: assert property (wr && cmd_code == 8'hE9 &&
    !cmd_wdata[4] && channel_adaptive[page] |-> ##3 !startup_submode[page])
    else $error("startup not left");
endmodule : avs_mode_chk
bind avs_mode_config_control avs_mode_chk u_chk (.core_clk(core_clk),
  .sys_rst(sys_rst), .nvm_mode_enable(nvm_mode_enable),
  .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
  .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_ack(rsp_ack),
  .rsp_rdata(rsp_rdata), .smb_alert_n(smb_alert_n),
  .bus_io_level_select(bus_io_level_select),
  .channel_adaptive(channel_adaptive), .startup_submode(startup_submode));

/* File: avs_mode_config_control.sv */
// Mode selection, write protection and reference control for two channels.
// Assumes a command port that presents one decoded byte command per pulse,
// and an adaptive bus frame decoder running on the link clock.

module avs_mode_config_control (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [1:0] nvm_mode_enable,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  output logic rsp_valid,
  output logic rsp_ack,
  output logic [15:0] rsp_rdata,
  output logic smb_alert_n,
  output logic bus_io_level_select,
  input wire logic [1:0] soft_start_active,
  input wire logic [15:0] ton_rise_step_cycles,
  output logic [1:0] channel_adaptive,
  output logic [1:0] startup_submode,
  output logic [9:0] vref_ch0,
  output logic [9:0] vref_ch1,
  input wire logic adaptive_bus_clock_pin,
  input wire logic frame_valid,
  input wire logic frame_channel,
  input wire logic [15:0] frame_value
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic strap_taken; // Power-up sample done
  logic [1:0] active_enable; // Enable bits in force since power-up
  logic page_sel; // Current page
  logic [15:0] cfg [2]; // Stored configuration per page
  logic [3:0] bus_address; // Adaptive bus device address
  logic [9:0] dac_default [2]; // Reference default per channel
  logic [15:0] extra0 [2]; // Further adaptive register
  logic [15:0] extra1 [2]; // Further adaptive register
  logic [15:0] trim_store [2][3]; // Trim and margin step values
  logic cml_other; // Sticky protected-write flag
  avs_mode_pkg::mode_e mode [2]; // Channel mode
  logic [9:0] bus_target [2]; // Target taken from bus frames
  logic [9:0] vref [2]; // Ramping reference
  logic [15:0] step_count [2]; // Cycles since last reference step
  // Link domain
  logic link_rst_s1, link_rst_s2; // Reset carried into link clock
  logic link_toggle; // Flips on each completed frame
  logic link_channel; // Held frame channel
  logic [15:0] link_value; // Held frame value
  // Crossing into core domain
  logic tog_s1, tog_s2, tog_s3; // Toggle synchroniser stages
  logic tog_seen; // Last toggle level acted upon
  logic frame_event; // New frame has arrived in core domain
  // Decode
  logic page_adaptive; // Selected page's channel in adaptive modes
  logic page_startup; // Selected page's channel in startup sub-mode
  logic is_protected; // Code is write-locked in this mode
  logic protect_hit; // Write refused by protection
  logic next_ack;
  logic [15:0] next_rdata, next_cfg_w;
  // ****************************************************************
  // Power-up sampling of the stored enable bits
  // ****************************************************************
  // Caught once after reset release; later writes wait for a power cycle
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      strap_taken <= 1'b0;
      active_enable <= 2'b00;
    end else if (!strap_taken) begin
      strap_taken <= 1'b1;
      active_enable <= nvm_mode_enable;
    end
  end
  // ****************************************************************
  // Command decode
  // ****************************************************************
  // Protection looks only at the page's own channel
  always_comb begin
    page_adaptive = (mode[page_sel] != avs_mode_pkg::MODE_PMBUS);
    page_startup = (mode[page_sel] == avs_mode_pkg::MODE_STARTUP);
    is_protected = 1'b0;
    if ((cmd_code == avs_mode_pkg::CMD_BUS_ADDRESS) ||
        (cmd_code == avs_mode_pkg::CMD_ADAPTIVE_EXTRA0) ||
        (cmd_code == avs_mode_pkg::CMD_ADAPTIVE_EXTRA1)) begin
      is_protected = page_adaptive;
    end else if (cmd_code == avs_mode_pkg::CMD_DAC_DEFAULT) begin
      is_protected = page_adaptive && !page_startup;
    end
    protect_hit = cmd_valid && cmd_write && is_protected;
    // Reserved bits never reach storage
    next_cfg_w = cmd_wdata & avs_mode_pkg::CFG_WRITABLE_MASK;
    if (page_sel) begin
      next_cfg_w[avs_mode_pkg::CFG_IO_LEVEL_BIT] = 1'b0;
    end
  end
  // ****************************************************************
  // Response: one cycle after each command
  // ****************************************************************
  always_comb begin
    next_ack = 1'b1;
    next_rdata = 16'h0000;
    case (cmd_code)
      avs_mode_pkg::CMD_PAGE: begin
        next_rdata = {15'h0000, page_sel};
      end
      avs_mode_pkg::CMD_COMMUNICATION_STATUS_REGISTER: begin
        next_rdata[avs_mode_pkg::CML_OTHER_BIT] = cml_other;
      end
      avs_mode_pkg::CMD_ADAPTIVE_CONFIG: begin
        next_rdata = cfg[page_sel];
      end
      avs_mode_pkg::CMD_BUS_ADDRESS: begin
        next_rdata = {12'h000, bus_address};
      end
      avs_mode_pkg::CMD_DAC_DEFAULT: begin
        next_rdata = {6'h00, dac_default[page_sel]};
      end
      avs_mode_pkg::CMD_ADAPTIVE_EXTRA0: begin
        next_rdata = extra0[page_sel];
      end
      avs_mode_pkg::CMD_ADAPTIVE_EXTRA1: begin
        next_rdata = extra1[page_sel];
      end
      avs_mode_pkg::CMD_VREF_TRIM,
      avs_mode_pkg::CMD_MARGIN_HIGH,
      avs_mode_pkg::CMD_MARGIN_LOW: begin
        // Both directions refused in adaptive modes
        next_ack = !page_adaptive;
        if (!page_adaptive) begin
          next_rdata = trim_store[page_sel][cmd_code[1:0]];
        end
      end
      default: begin
        next_ack = 1'b0; // Unknown codes are NACKed
      end
    endcase
  end

  // Answer registers
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rsp_valid <= 1'b0;
      rsp_ack <= 1'b0;
      rsp_rdata <= 16'h0000;
    end else begin
      rsp_valid <= cmd_valid;
      rsp_ack <= cmd_valid && next_ack;
      rsp_rdata <= (cmd_valid && !cmd_write) ? next_rdata : 16'h0000;
    end
  end
  // ****************************************************************
  // Register storage
  // ****************************************************************
  // Page select and shared address
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      page_sel <= 1'b0;
      bus_address <= avs_mode_pkg::ADDRESS_RESET;
    end else if (cmd_valid && cmd_write) begin
      if (cmd_code == avs_mode_pkg::CMD_PAGE) begin
        page_sel <= cmd_wdata[0];
      end
      if ((cmd_code == avs_mode_pkg::CMD_BUS_ADDRESS) && !is_protected) begin
        bus_address <= cmd_wdata[3:0];
      end
    end
  end

  // Paged registers: one copy per channel
  generate
    for (genvar p = 0; p < 2; p++) begin : g_page
      always_ff @(posedge core_clk) begin
        if (sys_rst) begin
          cfg[p] <= avs_mode_pkg::CFG_RESET;
          dac_default[p] <= avs_mode_pkg::DAC_DEFAULT_RESET;
          extra0[p] <= 16'h0000;
          extra1[p] <= 16'h0000;
          for (int k = 0; k < 3; k++) begin
            trim_store[p][k] <= 16'h0000;
          end
        end else if (cmd_valid && cmd_write && (page_sel == 1'(p))) begin
          case (cmd_code)
            avs_mode_pkg::CMD_ADAPTIVE_CONFIG: begin
              cfg[p] <= next_cfg_w;
            end
            avs_mode_pkg::CMD_DAC_DEFAULT: begin
              if (!is_protected) begin
                dac_default[p] <= cmd_wdata[9:0];
              end
            end
            avs_mode_pkg::CMD_ADAPTIVE_EXTRA0: begin
              if (!is_protected) begin
                extra0[p] <= cmd_wdata;
              end
            end
            avs_mode_pkg::CMD_ADAPTIVE_EXTRA1: begin
              if (!is_protected) begin
                extra1[p] <= cmd_wdata;
              end
            end
            avs_mode_pkg::CMD_VREF_TRIM,
            avs_mode_pkg::CMD_MARGIN_HIGH,
            avs_mode_pkg::CMD_MARGIN_LOW: begin
              if (!page_adaptive) begin
                trim_store[p][cmd_code[1:0]] <= cmd_wdata;
              end
            end
            default: begin
              // Other codes leave this page alone
            end
          endcase
        end
      end
    end
  endgenerate
  // ****************************************************************
  // Communication status flag and alert
  // ****************************************************************
  // A new refusal in the clearing cycle wins, so no event is lost
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cml_other <= 1'b0;
      smb_alert_n <= 1'b1;
    end else begin
      if (protect_hit) begin
        cml_other <= 1'b1;
      end else if (cmd_valid && cmd_write &&
                   (cmd_code == avs_mode_pkg::CMD_COMMUNICATION_STATUS_REGISTER) &&
                   cmd_wdata[avs_mode_pkg::CML_OTHER_BIT]) begin
        cml_other <= 1'b0;
      end
      smb_alert_n <= !(cml_other || protect_hit);
    end
  end
  // ****************************************************************
  // Interface level select, shared by both channels
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      bus_io_level_select <= 1'b0;
    end else begin
      bus_io_level_select <= cfg[0][avs_mode_pkg::CFG_IO_LEVEL_BIT];
    end
  end
  // ****************************************************************
  // Link side: hold each completed frame and flag it by toggle
  // ****************************************************************
  // Reset brought onto the link clock; link clock only runs with frames and around power-up
  always_ff @(posedge adaptive_bus_clock_pin) begin
    link_rst_s1 <= sys_rst;
    link_rst_s2 <= link_rst_s1;
  end

  // Frame holder; decoder spaces frames well beyond the crossing time
  always_ff @(posedge adaptive_bus_clock_pin) begin
    if (link_rst_s2) begin
      link_toggle <= 1'b0;
      link_channel <= 1'b0;
      link_value <= 16'h0000;
    end else if (frame_valid) begin
      link_toggle <= !link_toggle;
      link_channel <= frame_channel;
      link_value <= frame_value;
    end
  end

  // Three-stage synchroniser; acted on once stages two and three agree
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tog_s1 <= 1'b0;
      tog_s2 <= 1'b0;
      tog_s3 <= 1'b0;
      tog_seen <= 1'b0;
    end else begin
      tog_s1 <= link_toggle;
      tog_s2 <= tog_s1;
      tog_s3 <= tog_s2;
      if (tog_s2 == tog_s3) begin
        tog_seen <= tog_s3;
      end
    end
  end

  assign frame_event = (tog_s2 == tog_s3) && (tog_s3 != tog_seen);
  // ****************************************************************
  // Per-channel mode, targets and reference ramp
  // ****************************************************************
  generate
    for (genvar c = 0; c < 2; c++) begin : g_chan
      logic [9:0] target; // Where the reference is heading
      logic [15:0] step_period; // Cycles between 2 mV steps

      // Mode follows the enable in force and the live startup bit
      always_ff @(posedge core_clk) begin
        if (sys_rst) begin
          mode[c] <= avs_mode_pkg::MODE_PMBUS;
        end else if (!active_enable[c]) begin
          mode[c] <= avs_mode_pkg::MODE_PMBUS;
        end else if (cfg[c][avs_mode_pkg::CFG_STARTUP_BIT]) begin
          mode[c] <= avs_mode_pkg::MODE_STARTUP;
        end else begin
          mode[c] <= avs_mode_pkg::MODE_ADAPTIVE;
        end
      end

      // Frames count only in full adaptive mode; ones during startup drop
      always_ff @(posedge core_clk) begin
        if (sys_rst) begin
          bus_target[c] <= avs_mode_pkg::DAC_DEFAULT_RESET;
        end else if (mode[c] != avs_mode_pkg::MODE_ADAPTIVE) begin
          bus_target[c] <= dac_default[c];
        end else if (frame_event && (link_channel == 1'(c))) begin
          bus_target[c] <= link_value[9:0];
        end
      end

      always_comb begin
        if (mode[c] == avs_mode_pkg::MODE_ADAPTIVE) begin
          target = bus_target[c];
        end else begin
          target = dac_default[c];
        end
        if (soft_start_active[c]) begin
          step_period = ton_rise_step_cycles;
        end else if (cfg[c][avs_mode_pkg::CFG_SLEW_BIT]) begin
          step_period = 16'(avs_mode_pkg::SLOW_STEP_CYCLES);
        end else begin
          step_period = 16'(avs_mode_pkg::FAST_STEP_CYCLES);
        end
      end

      // One DAC step per period; the period counter paces the slew
      always_ff @(posedge core_clk) begin
        if (sys_rst) begin
          vref[c] <= avs_mode_pkg::DAC_DEFAULT_RESET;
          step_count[c] <= 16'h0000;
        end else if (vref[c] == target) begin
          step_count[c] <= 16'h0000;
        end else if (step_count[c] + 16'h0001 >= step_period) begin
          step_count[c] <= 16'h0000;
          if (vref[c] < target) begin
            vref[c] <= vref[c] + 10'h001;
          end else begin
            vref[c] <= vref[c] - 10'h001;
          end
        end else begin
          step_count[c] <= step_count[c] + 16'h0001;
        end
      end

      // Registered mode status
      always_ff @(posedge core_clk) begin
        if (sys_rst) begin
          channel_adaptive[c] <= 1'b0;
          startup_submode[c] <= 1'b0;
        end else begin
          channel_adaptive[c] <= (mode[c] != avs_mode_pkg::MODE_PMBUS);
          startup_submode[c] <= (mode[c] == avs_mode_pkg::MODE_STARTUP);
        end
      end
    end
  endgenerate
  assign vref_ch0 = vref[0];
  assign vref_ch1 = vref[1];

endmodule : avs_mode_config_control

/* File: avs_mode_config_control_tb.sv */
// Self-checking bench: command sequences plus adaptive bus frames.
// Assumes the frame master model and the bound checker are compiled.
module avs_mode_config_control_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk, sys_rst, cv, cw, run_link, rv, ra, alert_n, io;
  logic [1:0] nvm, ss, ca, su;
  logic [7:0] cc, k;
  logic [15:0] cd, ton, rd, fval;
  logic [9:0] v0, v1;
  logic lclk, fv, fch;
  int num_errors, check_count, cyc;
  avs_mode_config_control DUT (.core_clk(core_clk), .sys_rst(sys_rst),
    .nvm_mode_enable(nvm), .cmd_valid(cv), .cmd_write(cw), .cmd_code(cc),
    .cmd_wdata(cd), .rsp_valid(rv), .rsp_ack(ra), .rsp_rdata(rd),
    .smb_alert_n(alert_n), .bus_io_level_select(io),
    .soft_start_active(ss), .ton_rise_step_cycles(ton),
    .channel_adaptive(ca), .startup_submode(su), .vref_ch0(v0),
    .vref_ch1(v1), .adaptive_bus_clock_pin(lclk), .frame_valid(fv),
    .frame_channel(fch), .frame_value(fval));
  avs_frame_master u_master (.run_link(run_link), .link_clk(lclk),
    .frame_valid(fv), .frame_channel(fch), .frame_value(fval));
  always #5 core_clk = ~core_clk;
  // Hang guard, well above the expected run length
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      final_report();
    end
  end
  task check(input string what, input logic [15:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // One command pulse; answer is sampled the cycle after
  task access(input logic wr, input logic [7:0] code,
    input logic [15:0] data, input logic eack, input logic [15:0] erd);
    @(negedge core_clk);
    cv = 1'b1;
    cw = wr;
    cc = code;
    cd = data;
    @(negedge core_clk);
    cv = 1'b0;
    check("rsp_valid", {15'h0000, rv}, 16'h0001);
    check("rsp_ack", {15'h0000, ra}, {15'h0000, eack});
    if (!wr && eack) check("rsp_rdata", rd, erd);
  endtask : access
  task wait_cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : wait_cyc
  // Power cycle; link clock runs so its reset flops clear
  task power_up(input logic [1:0] en);
    nvm = en;
    sys_rst = 1'b1;
    run_link = 1'b1;
    wait_cyc(8);
    sys_rst = 1'b0;
    wait_cyc(4);
    run_link = 1'b0;
  endtask : power_up
  task final_report();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    core_clk = 1'b0;
    {sys_rst, cv, cw, run_link} = 4'h9;
    {nvm, ss, cc, cd, ton} = 44'h0;
    num_errors = 0;
    check_count = 0;
    cyc = 0;
    power_up(2'b00);
    access(1'b0, 8'hE9, 16'h0000, 1'b1, 16'h0002);
    access(1'b0, 8'hEA, 16'h0000, 1'b1, 16'h0005);
    access(1'b0, 8'hEB, 16'h0000, 1'b1, 16'h01F4);
    check("adaptive", {14'h0000, ca}, 16'h0000);
    access(1'b1, 8'hD4, 16'h0001, 1'b1, 16'h0000);
    access(1'b1, 8'hE9, 16'hFFFF, 1'b1, 16'h0000);
    access(1'b0, 8'hE9, 16'h0000, 1'b1, 16'h803F);
    wait_cyc(4);
    check("startup", {14'h0000, su}, 16'h0000);
    check("adaptive", {14'h0000, ca}, 16'h0000);
    check("io", {15'h0000, io}, 16'h0001);
    access(1'b1, 8'h00, 16'h0001, 1'b1, 16'h0000);
    access(1'b1, 8'hE9, 16'hFFFF, 1'b1, 16'h0000);
    access(1'b0, 8'hE9, 16'h0000, 1'b1, 16'h801F);
    check("io", {15'h0000, io}, 16'h0001);
    $display("test pmbus mode done");
    power_up(2'b01);
    check("adaptive", {14'h0000, ca}, 16'h0001);
    for (k = 8'hD4; k <= 8'hD6; k++) begin
      access(1'b0, k, 16'h0000, 1'b0, 16'h0000);
      access(1'b1, k, 16'h0001, 1'b0, 16'h0000);
    end
    access(1'b1, 8'hEB, 16'h0123, 1'b1, 16'h0000);
    wait_cyc(2);
    check("alert_n", {15'h0000, alert_n}, 16'h0000);
    access(1'b0, 8'hEB, 16'h0000, 1'b1, 16'h01F4);
    access(1'b1, 8'h7E, 16'h0002, 1'b1, 16'h0000);
    wait_cyc(2);
    check("alert_n", {15'h0000, alert_n}, 16'h0001);
    access(1'b1, 8'hEA, 16'h000A, 1'b1, 16'h0000);
    access(1'b0, 8'hEA, 16'h0000, 1'b1, 16'h0005);
    access(1'b1, 8'h7E, 16'h0002, 1'b1, 16'h0000);
    access(1'b1, 8'h00, 16'h0001, 1'b1, 16'h0000);
    access(1'b1, 8'hEB, 16'h0155, 1'b1, 16'h0000);
    access(1'b1, 8'hD4, 16'h0001, 1'b1, 16'h0000);
    access(1'b1, 8'h00, 16'h0000, 1'b1, 16'h0000);
    u_master.send_frame(1'b1, 16'h0100);
    $display("test protection done");
    u_master.send_frame(1'b0, 16'h01F7);
    wait_cyc(150);
    check("vref_ch0", {6'h00, v0}, 16'h01F7);
    ss = 2'b01;
    ton = 16'h0010;
    access(1'b1, 8'hE9, 16'h0010, 1'b1, 16'h0000);
    wait_cyc(70);
    check("vref_ch0", {6'h00, v0}, 16'h01F4);
    ss = 2'b00;
    access(1'b1, 8'hEB, 16'h01F6, 1'b1, 16'h0000);
    check("alert_n", {15'h0000, alert_n}, 16'h0001);
    wait_cyc(100);
    check("vref_ch0", {6'h00, v0}, 16'h01F6);
    u_master.send_frame(1'b0, 16'h0100);
    wait_cyc(100);
    check("vref_ch0", {6'h00, v0}, 16'h01F6);
    access(1'b1, 8'hE9, 16'h0000, 1'b1, 16'h0000);
    wait_cyc(3);
    check("startup", {14'h0000, su}, 16'h0000);
    u_master.send_frame(1'b0, 16'h01F8);
    wait_cyc(150);
    check("vref_ch0", {6'h00, v0}, 16'h01F8);
    access(1'b1, 8'hE9, 16'h0001, 1'b1, 16'h0000);
    u_master.send_frame(1'b0, 16'h01F9);
    wait_cyc(200);
    check("vref_ch0", {6'h00, v0}, 16'h01F8);
    wait_cyc(3000);
    check("vref_ch0", {6'h00, v0}, 16'h01F9);
    wait_cyc(1600);
    check("vref_ch1", {6'h00, v1}, 16'h0155);
    $display("test adaptive mode done");
    final_report();
  end
endmodule : avs_mode_config_control_tb

/* File: avs_mode_pkg.sv */
// Constants shared by the adaptive voltage mode and configuration logic.
// Assumes a byte-command register port in front of it and a frame decoder
// on the adaptive bus that reports each completed write frame.
package avs_mode_pkg;

  // ****************************************************************
  // Command codes
  // ****************************************************************
  localparam logic [7:0] CMD_PAGE = 8'h00;
  localparam logic [7:0] CMD_COMMUNICATION_STATUS_REGISTER = 8'h7E;
  localparam logic [7:0] CMD_VREF_TRIM = 8'hD4;
  localparam logic [7:0] CMD_MARGIN_HIGH = 8'hD5;
  localparam logic [7:0] CMD_MARGIN_LOW = 8'hD6;
  localparam logic [7:0] CMD_ADAPTIVE_CONFIG = 8'hE9;
  localparam logic [7:0] CMD_BUS_ADDRESS = 8'hEA;
  localparam logic [7:0] CMD_DAC_DEFAULT = 8'hEB;
  localparam logic [7:0] CMD_ADAPTIVE_EXTRA0 = 8'hEC;
  localparam logic [7:0] CMD_ADAPTIVE_EXTRA1 = 8'hED;

  // ****************************************************************
  // Configuration field positions
  // ****************************************************************
  localparam int CFG_ENABLE_BIT = 15;
  localparam int CFG_IO_LEVEL_BIT = 5;
  localparam int CFG_STARTUP_BIT = 4;
  localparam int CFG_DOUBLE_COMMIT_BIT = 3;
  localparam int CFG_PAYLOAD_LSB = 1;
  localparam int CFG_SLEW_BIT = 0;
  localparam logic [15:0] CFG_WRITABLE_MASK = 16'h803F;
  localparam int CML_OTHER_BIT = 1;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [15:0] CFG_RESET = 16'h0002;
  localparam logic [3:0] ADDRESS_RESET = 4'h5;
  localparam logic [9:0] DAC_DEFAULT_RESET = 10'h1F4;

  // ****************************************************************
  // Timing: reference slew rates, DAC step is 2 mV
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int SLEW_WINDOW_US = 30;
  localparam int FAST_SLEW_MV = 200;
  localparam int SLOW_SLEW_MV = 2;
  localparam int DAC_LSB_MV = 2;
  localparam int WINDOW_CYCLES = SLEW_WINDOW_US * 1000 / CLK_PERIOD_NS;
  localparam int FAST_STEP_CYCLES = WINDOW_CYCLES * DAC_LSB_MV / FAST_SLEW_MV;
  localparam int SLOW_STEP_CYCLES = WINDOW_CYCLES * DAC_LSB_MV / SLOW_SLEW_MV;

  // ****************************************************************
  // Channel operating modes
  // ****************************************************************
  typedef enum logic [1:0] {
    MODE_PMBUS,
    MODE_ADAPTIVE,
    MODE_STARTUP
  } mode_e;

endpackage : avs_mode_pkg
